// [design/pad_attr_decode.sv]
// Cache attribute decode from extension, cacheable and bufferable bits
`timescale 1ns/100ps
module pad_attr_decode
    import pad_pkg::*;
(
    input  wire logic ext_bit,
    input  wire logic cacheable,
    input  wire logic bufferable,
    output logic      is_cacheable,
    output logic      write_alloc,
    output logic      write_through,
    output logic      mini_cache
);
    // ==========================================================
    // Attribute table
    always_comb
    begin
        is_cacheable  = 1'b0;
        write_alloc   = 1'b0;
        write_through = 1'b0;
        mini_cache    = 1'b0;
        if (ext_bit)
        begin
            unique case ({cacheable, bufferable})
                2'b00: ;                       // Uncached variant
                2'b01: ;                       // Reserved combination
                2'b10:
                begin
                    is_cacheable = 1'b1;
                    mini_cache   = 1'b1;
                end
                2'b11:
                begin
                    is_cacheable = 1'b1;
                    write_alloc  = 1'b1;
                end
            endcase
        end
        else
        begin
            unique case ({cacheable, bufferable})
                2'b00: ;                       // Uncached, unbuffered
                2'b01: ;                       // Buffered only
                2'b10:
                begin
                    is_cacheable  = 1'b1;
                    write_through = 1'b1;      // Replaces old mini-cache code
                end
                2'b11: is_cacheable = 1'b1;    // Write-back
            endcase
        end
    end
endmodule // pad_attr_decode

// [design/pad_decode.sv]
// Page attribute decode, fill policy, exception classification, update wait
`timescale 1ns/100ps
//
// Contract
// - X=1 makes C,B select four extra attributes incl. mini-cache, write-allocate.
// - X=0 keeps standard C,B meaning; old mini-cache code becomes write-through.
// - With write-allocate, a cacheable store miss starts a line fill.
// - Without write-allocate only a cacheable load miss fills.
// - Write-through pages send every store to memory.
// - Coarse types: fault, large, small, extended small with extension field.
// - Fine type 11 is tiny page; others as coarse.
// - Only the extension field's lowest bit is used as X.
// - Small pages behave as if X were zero.
// - After the wait sequence ends all control writes have taken effect.
// - Precise exceptions let the link register locate the faulting instruction.
// - Reset, interrupts, external and parity data aborts are imprecise.
// - Only the data translation abort writes the fault address register.
module pad_decode
    import pad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        desc_valid,
    input  wire logic        desc_level2,
    input  wire logic        desc_fine,
    input  wire logic [31:0] desc_word,
    input  wire logic        acc_valid,
    input  wire logic        acc_store,
    input  wire logic        acc_miss,
    output logic             line_fill,
    output logic             mem_write,
    output logic             page_fault,
    output logic             mini_alloc,
    input  wire logic        exc_valid,
    input  wire pad_exc_t    exc_kind,
    input  wire logic [31:0] exc_addr,
    output logic             exc_precise,
    output logic             ctrl_applied,
    output logic             wait_done
);
    // ==========================================================
    // Descriptor decode
    pad_page_t  page_kind;
    logic       ext_bit;
    logic       is_cacheable;
    logic       write_alloc;
    logic       write_through;
    logic       mini_cache;
    logic [1:0] perm;

    function automatic pad_page_t l2_kind(input logic [1:0] code, input logic fine);
        pad_page_t k;
        k = PAD_PG_FAULT;
        unique case (code)
            2'b00: k = PAD_PG_FAULT;
            2'b01: k = PAD_PG_LARGE;
            2'b10: k = PAD_PG_SMALL;
            2'b11: k = fine ? PAD_PG_TINY : PAD_PG_XSMALL;
        endcase
        return k;
    endfunction

    // Page kind, extension bit and permission field
    always_comb
    begin
        page_kind = PAD_PG_FAULT;
        ext_bit   = 1'b0;
        perm      = desc_word[L2_AP_LSB +: 2];
        if (!desc_level2)
        begin
            unique case (pad_l1_t'(desc_word[DESC_TYPE_LSB +: 2]))
                PAD_L1_FAULT:   page_kind = PAD_PG_FAULT;
                PAD_L1_COARSE:  page_kind = PAD_PG_FAULT;  // Table pointer, no attributes
                PAD_L1_SECTION:
                begin
                    page_kind = PAD_PG_SECT;
                    ext_bit   = desc_word[L1_TEX_LSB];
                    perm      = desc_word[L1_AP_LSB +: 2];
                end
                PAD_L1_FINE:    page_kind = PAD_PG_FAULT;
            endcase
        end
        else
        begin
            page_kind = l2_kind(desc_word[DESC_TYPE_LSB +: 2], desc_fine);
            if (page_kind == PAD_PG_XSMALL || page_kind == PAD_PG_TINY)
                ext_bit = desc_word[L2_TEX_LSB];
            else
                ext_bit = 1'b0;
        end
    end

    pad_attr_decode u_attr (
        .ext_bit       (ext_bit),
        .cacheable     (desc_word[DESC_C_BIT]),
        .bufferable    (desc_word[DESC_B_BIT]),
        .is_cacheable  (is_cacheable),
        .write_alloc   (write_alloc),
        .write_through (write_through),
        .mini_cache    (mini_cache)
    );

    // ==========================================================
    // Latched attributes of the current page
    logic      attr_c, attr_wa, attr_wt, attr_mini, attr_fault, attr_table;
    logic      next_attr_c, next_attr_wa, next_attr_wt, next_attr_mini, next_attr_fault;
    logic      next_attr_table;
    logic [1:0] attr_perm, next_attr_perm;

    always_comb
    begin
        next_attr_c     = attr_c;
        next_attr_wa    = attr_wa;
        next_attr_wt    = attr_wt;
        next_attr_mini  = attr_mini;
        next_attr_fault = attr_fault;
        next_attr_perm  = attr_perm;
        next_attr_table = attr_table;
        if (desc_valid)
        begin
            next_attr_c     = is_cacheable;
            next_attr_wa    = write_alloc;
            next_attr_wt    = write_through;
            next_attr_mini  = mini_cache;
            next_attr_perm  = perm;
            next_attr_table = !desc_level2 && desc_word[DESC_TYPE_LSB];
            next_attr_fault = desc_word[DESC_TYPE_LSB +: 2] == 2'b00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            attr_c     <= 1'b0;
            attr_wa    <= 1'b0;
            attr_wt    <= 1'b0;
            attr_mini  <= 1'b0;
            attr_fault <= 1'b1;
            attr_perm  <= 2'b00;
            attr_table <= 1'b0;
        end
        else
        begin
            attr_c     <= next_attr_c;
            attr_wa    <= next_attr_wa;
            attr_wt    <= next_attr_wt;
            attr_mini  <= next_attr_mini;
            attr_fault <= next_attr_fault;
            attr_perm  <= next_attr_perm;
            attr_table <= next_attr_table;
        end
    end

    // ==========================================================
    // Access policy: fills and memory writes
    logic next_line_fill, next_mem_write, next_page_fault, next_mini_alloc;

    always_comb
    begin
        next_line_fill  = 1'b0;
        next_mem_write  = 1'b0;
        next_page_fault = acc_valid && attr_fault;
        next_mini_alloc = 1'b0;
        if (acc_valid && !attr_fault)
        begin
            if (acc_store)
            begin
                next_line_fill = acc_miss && attr_c && attr_wa;
                next_mem_write = attr_wt || !attr_c || acc_miss && !attr_wa;
            end
            else
                next_line_fill = acc_miss && attr_c;
            next_mini_alloc = next_line_fill && attr_mini;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            line_fill  <= 1'b0;
            mem_write  <= 1'b0;
            page_fault <= 1'b0;
            mini_alloc <= 1'b0;
        end
        else
        begin
            line_fill  <= next_line_fill;
            mem_write  <= next_mem_write;
            page_fault <= next_page_fault;
            mini_alloc <= next_mini_alloc;
        end
    end

    // ==========================================================
    // Exception classification and fault address
    logic                 next_exc_precise;
    logic [FAR_WIDTH-1:0] fault_addr, next_fault_addr;
    logic                 far_event;

    always_comb
    begin
        unique case (exc_kind)
            PAD_EX_RESET, PAD_EX_FAST, PAD_EX_IRQ,
            PAD_EX_D_EXT, PAD_EX_D_PAR: next_exc_precise = 1'b0;
            PAD_EX_I_EXT, PAD_EX_I_MMU, PAD_EX_I_PAR, PAD_EX_LOCK,
            PAD_EX_D_MMU, PAD_EX_SWI, PAD_EX_UNDEF: next_exc_precise = 1'b1;
            default: next_exc_precise = 1'b0;
        endcase
        if (!exc_valid)
            next_exc_precise = exc_precise;
        far_event       = exc_valid && exc_kind == PAD_EX_D_MMU;
        next_fault_addr = far_event ? exc_addr : fault_addr;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            exc_precise <= 1'b0;
            fault_addr  <= RESET_ZERO;
        end
        else
        begin
            exc_precise <= next_exc_precise;
            fault_addr  <= next_fault_addr;
        end
    end

    // ==========================================================
    // Control writes and wait sequence
    pad_wait_t  wstate, next_wstate;
    logic [3:0] wcount, next_wcount;
    logic [7:0] ctrl_reg, ctrl_live, next_ctrl_live;
    logic       next_ctrl_applied, next_wait_done;
    logic       wait_req, ctrl_wr;

    assign ctrl_wr  = reg_write && reg_addr == REG_CTRL;
    assign wait_req = reg_write && reg_addr == REG_EXC;   // Wait sequence issued

    always_comb
    begin
        next_wstate    = wstate;
        next_wcount    = wcount;
        next_ctrl_live = ctrl_live;
        next_wait_done = 1'b0;
        if (ctrl_wr)
            next_wcount = APPLY_DELAY;                    // Restart on each write
        else if (wcount != 4'h0)
            next_wcount = wcount - 4'h1;
        if (wcount == 4'h1)
            next_ctrl_live = ctrl_reg;                    // May take effect early
        unique case (wstate)
            PAD_WAIT_IDLE:  if (wait_req) next_wstate = PAD_WAIT_APPLY;
            PAD_WAIT_APPLY:
                if (wcount == 4'h0 && !ctrl_wr)
                begin
                    next_ctrl_live = ctrl_reg;
                    next_wstate    = PAD_WAIT_DONE;
                end
            PAD_WAIT_DONE:
            begin
                next_wait_done = 1'b1;
                next_wstate    = PAD_WAIT_IDLE;
            end
            default: next_wstate = PAD_WAIT_IDLE;
        endcase
        next_ctrl_applied = next_ctrl_live == ctrl_reg;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wstate       <= PAD_WAIT_IDLE;
            wcount       <= 4'h0;
            ctrl_live    <= 8'h00;
            ctrl_applied <= 1'b1;
            wait_done    <= 1'b0;
        end
        else
        begin
            wstate       <= next_wstate;
            wcount       <= next_wcount;
            ctrl_live    <= next_ctrl_live;
            ctrl_applied <= next_ctrl_applied;
            wait_done    <= next_wait_done;
        end
    end

    // ==========================================================
    // Register file, sticky status and interrupt
    logic [ST_WIDTH-1:0] status, next_status, mask, next_mask, events;
    logic [7:0]          next_ctrl_reg;
    logic [31:0]         next_rdata;
    logic                next_irq;

    always_comb
    begin
        events = '0;
        events[ST_WAIT_DONE] = next_wait_done;
        events[ST_FAR_WRITE] = far_event;
        events[ST_FILL]      = next_line_fill;
        events[ST_BAD_DESC]  = desc_valid && !desc_level2 && desc_word[L1_P_BIT];
        next_status   = status;
        next_mask     = mask;
        next_ctrl_reg = ctrl_reg;
        if (reg_write && reg_addr == REG_STATUS)
            next_status = status & ~reg_wdata[ST_WIDTH-1:0];
        next_status = next_status | events;               // Set wins over clear
        if (reg_write && reg_addr == REG_MASK)
            next_mask = reg_wdata[ST_WIDTH-1:0];
        if (ctrl_wr)
            next_ctrl_reg = reg_wdata[7:0];               // Bit 1 kept zero by software
        next_irq   = |(next_status & next_mask);
        next_rdata = RESET_ZERO;
        if (reg_read)
        begin
            unique case (reg_addr)
                REG_STATUS: next_rdata = {28'h0, status};
                REG_MASK:   next_rdata = {28'h0, mask};
                REG_FAULT:  next_rdata = fault_addr;
                REG_CTRL:   next_rdata = {24'h0, ctrl_reg};
                REG_ATTR:   next_rdata = {25'h0, attr_table, attr_perm, attr_mini,
                                          attr_wt, attr_wa, attr_c};
                REG_EXC:    next_rdata = {28'h0, 1'b0, wstate, exc_precise};
                default:    next_rdata = RESET_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            status    <= '0;
            mask      <= '0;
            ctrl_reg  <= 8'h00;
            reg_rdata <= RESET_ZERO;
            irq       <= 1'b0;
        end
        else
        begin
            status    <= next_status;
            mask      <= next_mask;
            ctrl_reg  <= next_ctrl_reg;
            reg_rdata <= next_rdata;
            irq       <= next_irq;
        end
    end

    // ==========================================================
    // Checks
    a_store_fill_wa: assert property (@(posedge clk) disable iff (reset)
        acc_valid && acc_store && acc_miss && !attr_fault && attr_c && attr_wa |=> line_fill)
        else $error("store miss with write-allocate did not fill");
    a_store_nofill: assert property (@(posedge clk) disable iff (reset)
        acc_valid && acc_store && !attr_wa |=> !line_fill)
        else $error("store miss filled without write-allocate");
    a_load_fill: assert property (@(posedge clk) disable iff (reset)
        acc_valid && !acc_store && acc_miss && attr_c && !attr_fault |=> line_fill)
        else $error("cacheable load miss did not fill");
    a_wt_store: assert property (@(posedge clk) disable iff (reset)
        acc_valid && acc_store && attr_wt && !attr_fault |=> mem_write)
        else $error("write-through store not sent to memory");
    a_x0_wt_code: assert property (@(posedge clk) disable iff (reset)
        desc_valid && desc_level2 && desc_word[1:0] == 2'b10 && desc_word[3:2] == 2'b10
        |=> attr_wt && !attr_mini)
        else $error("small page C=1 B=0 not write-through");
    a_x1_walloc: assert property (@(posedge clk) disable iff (reset)
        desc_valid && desc_level2 && desc_word[1:0] == 2'b11 && desc_word[6] && desc_word[3:2] == 2'b11
        |=> attr_wa && !attr_wt)
        else $error("extended page X=1 C=1 B=1 not write-allocate");
    a_far_only_mmu: assert property (@(posedge clk) disable iff (reset)
        !(exc_valid && exc_kind == PAD_EX_D_MMU) |=> fault_addr == $past(fault_addr))
        else $error("fault address changed by other exception");
    a_imprecise: assert property (@(posedge clk) disable iff (reset)
        exc_valid && (exc_kind == PAD_EX_IRQ || exc_kind == PAD_EX_D_EXT) |=> !exc_precise)
        else $error("imprecise exception flagged precise");
    a_wait_applied: assert property (@(posedge clk) disable iff (reset)
        wait_done |-> ctrl_applied)
        else $error("wait finished before control took effect");
endmodule // pad_decode

// [design/pad_pkg.sv]
// Package of constants and types for the page attribute and exception decode block
package pad_pkg;
    // ==========================================================
    // Descriptor field positions
    localparam int DESC_TYPE_LSB  = 0;
    localparam int DESC_B_BIT     = 2;
    localparam int DESC_C_BIT     = 3;
    localparam int L1_P_BIT       = 9;
    localparam int L1_TEX_LSB     = 12;
    localparam int L2_TEX_LSB     = 6;
    localparam int L1_AP_LSB      = 10;
    localparam int L2_AP_LSB      = 4;
    localparam int FAR_WIDTH      = 32;
    // ==========================================================
    // Register offsets (word addresses)
    localparam logic [3:0] REG_STATUS  = 4'h0;
    localparam logic [3:0] REG_MASK    = 4'h1;
    localparam logic [3:0] REG_FAULT   = 4'h2;
    localparam logic [3:0] REG_CTRL    = 4'h3;
    localparam logic [3:0] REG_ATTR    = 4'h4;
    localparam logic [3:0] REG_EXC     = 4'h5;
    localparam logic [31:0] RESET_ZERO = 32'h0;
    // Status bit positions
    localparam int ST_WAIT_DONE = 0;
    localparam int ST_FAR_WRITE = 1;
    localparam int ST_FILL      = 2;
    localparam int ST_BAD_DESC  = 3;
    localparam int ST_WIDTH     = 4;
    // Clock cycles after a control write before it takes effect
    localparam logic [3:0] APPLY_DELAY = 4'h3;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PAD_L1_FAULT   = 2'b00,
        PAD_L1_COARSE  = 2'b01,
        PAD_L1_SECTION = 2'b10,
        PAD_L1_FINE    = 2'b11
    } pad_l1_t;
    typedef enum logic [2:0] {
        PAD_PG_FAULT = 3'h0,
        PAD_PG_LARGE = 3'h1,
        PAD_PG_SMALL = 3'h2,
        PAD_PG_XSMALL = 3'h3,
        PAD_PG_TINY  = 3'h4,
        PAD_PG_SECT  = 3'h5
    } pad_page_t;
    typedef enum logic [3:0] {
        PAD_EX_RESET   = 4'h0,
        PAD_EX_FAST    = 4'h1,
        PAD_EX_IRQ     = 4'h2,
        PAD_EX_I_EXT   = 4'h3,
        PAD_EX_I_MMU   = 4'h4,
        PAD_EX_I_PAR   = 4'h5,
        PAD_EX_LOCK    = 4'h6,
        PAD_EX_D_MMU   = 4'h7,
        PAD_EX_D_EXT   = 4'h8,
        PAD_EX_D_PAR   = 4'h9,
        PAD_EX_SWI     = 4'hA,
        PAD_EX_UNDEF   = 4'hB
    } pad_exc_t;
    typedef enum logic [1:0] {
        PAD_WAIT_IDLE  = 2'b00,
        PAD_WAIT_APPLY = 2'b01,
        PAD_WAIT_DONE  = 2'b10
    } pad_wait_t;
endpackage

// [tb/pad_table_model.sv]
// Translation table entries as software lays them out in memory
`timescale 1ns/100ps
module pad_table_model
    import pad_pkg::*;
(
    input  wire logic [2:0]  sel,
    input  wire logic        c,
    input  wire logic        b,
    input  wire logic        x,
    output logic      [31:0] word,
    output logic             level2,
    output logic             fine
);
    // ==========================================================
    // Descriptor forms, reserved first-level bit always zero
    always_comb
    begin
        case (sel)
            3'h0: word = 32'h00100012 | {19'h0, x, 12'h0} | {28'h0, c, b, 2'h0};
            3'h1: word = 32'h00106012 | {28'h0, c, b, 2'h0};
            3'h2: word = 32'h00001003 | {25'h0, x, 6'h0} | {28'h0, c, b, 2'h0};
            3'h3: word = 32'h00000203 | {25'h0, x, 6'h0} | {28'h0, c, b, 2'h0};
            3'h4: word = 32'h00002042 | {28'h0, c, b, 2'h0};
            3'h7: word = 32'h00004001;
            default: word = 32'h00000000;
        endcase
        level2 = (sel == 3'h2) || (sel == 3'h3) || (sel == 3'h4) || (sel == 3'h6);
        fine   = (sel == 3'h3);
    end
endmodule // pad_table_model

// [tb/test_pad_decode.sv]
// Self-checking testbench for the page attribute and exception decode block
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module test_pad_decode
    import pad_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, exc_addr = 32'h0, reg_rdata, desc_word;
    logic desc_valid = 1'b0, acc_valid = 1'b0, acc_store = 1'b0, acc_miss = 1'b0, exc_valid = 1'b0;
    logic [2:0] sel = 3'h0;
    logic c = 1'b0, b = 1'b0, x = 1'b0, desc_level2, desc_fine;
    logic irq, line_fill, mem_write, page_fault, exc_precise, ctrl_applied, wait_done, mini_alloc;
    pad_exc_t exc_kind = PAD_EX_RESET;
    int num_errors = 0, checks = 0;
    bit got;
    // ==========================================================
    // Clock, partner and design
    always #5 clk = ~clk;
    pad_table_model i_table (.sel(sel), .c(c), .b(b), .x(x), .word(desc_word), .level2(desc_level2),
                             .fine(desc_fine));
    pad_decode i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .desc_valid(desc_valid), .desc_level2(desc_level2), .desc_fine(desc_fine), .desc_word(desc_word),
        .acc_valid(acc_valid), .acc_store(acc_store), .acc_miss(acc_miss), .line_fill(line_fill),
        .mem_write(mem_write), .page_fault(page_fault), .mini_alloc(mini_alloc), .exc_valid(exc_valid),
        .exc_kind(exc_kind), .exc_addr(exc_addr), .exc_precise(exc_precise),
        .ctrl_applied(ctrl_applied), .wait_done(wait_done));
    // ==========================================================
    // Bus and stimulus tasks
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic page(input logic [2:0] s, input logic cc, input logic bb, input logic xx);
        @(posedge clk);
        sel        <= s;
        c          <= cc;
        b          <= bb;
        x          <= xx;
        desc_valid <= 1'b1;
        @(posedge clk);
        desc_valid <= 1'b0;
    endtask
    task automatic acc(input logic st, input logic ms, input logic fl, input logic mw, input logic ft,
                       input logic mi);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_store <= st;
        acc_miss  <= ms;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1;
        `CHK(line_fill, fl)
        `CHK(mem_write, mw)
        `CHK(page_fault, ft)
        `CHK(mini_alloc, mi)
    endtask
    task automatic exc(input int k, input logic p);
        @(posedge clk);
        exc_valid <= 1'b1;
        exc_kind  <= pad_exc_t'(k[3:0]);
        exc_addr  <= 32'hA0000000 + k;
        @(posedge clk);
        exc_valid <= 1'b0;
        #1;
        `CHK(exc_precise, p)
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        logic xe, wa, wt, fl, mw;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(REG_STATUS, 32'h0);
        `CHK(ctrl_applied, 1'b1)
        // Every attribute code on the section, extended small, tiny and small page forms, loads and stores, hits and misses
        for (int s = 0; s < 5; s++)
            for (int cb = 0; cb < 4; cb++)
                for (int xx = 0; xx < 2; xx++)
                begin
                    page(s[2:0], cb[1], cb[0], xx[0]);
                    xe = (s == 0 || s == 2 || s == 3) ? xx[0] : 1'b0;
                    wa = xe & cb[1] & cb[0];
                    wt = !xe & cb[1] & !cb[0];
                    for (int m = 0; m < 4; m++)
                    begin
                        fl = cb[1] & m[0] & (!m[1] | wa);
                        mw = m[1] & (wt | !cb[1] | (m[0] & !wa));
                        acc(m[1], m[0], fl, mw, 1'b0, fl & xe & cb[1] & !cb[0]);
                    end
                end
        // Fault descriptors fault; a first-level table pointer is uncached, not a fault
        for (int s = 5; s < 8; s++)
        begin
            page(s[2:0], 1'b1, 1'b1, 1'b0);
            acc(1'b0, 1'b1, 1'b0, 1'b0, s != 7, 1'b0);
        end
        rd(REG_ATTR, 32'h40);
        // Line fill event raises the interrupt until cleared
        wr(REG_MASK, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b1)
        wr(REG_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, 1'b0)
        rd(REG_STATUS, 32'h0);
        rd(REG_MASK, 32'h4);
        // Every exception kind, only the data translation abort records its address
        for (int k = 0; k < 12; k++)
            exc(k, (k >= 3 && k <= 7) || k >= 10);
        rd(REG_EXC, 32'h1);
        rd(REG_FAULT, 32'hA0000007);
        rd(REG_STATUS, 32'h2);
        wr(REG_STATUS, 32'h2);
        // Two control writes covered by one wait, auxiliary bit 1 kept zero
        wr(REG_CTRL, 32'h5);
        wr(REG_CTRL, 32'h9);
        wr(REG_EXC, 32'h0);
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++)
        begin
            @(posedge clk);
            #1;
            got = (wait_done === 1'b1);
        end
        `CHK(got, 1'b1)
        `CHK(ctrl_applied, 1'b1)
        rd(REG_STATUS, 32'h1);
        rd(REG_CTRL, 32'h9);
        // Unmapped place ignores writes and reads as zero
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF, 32'h0);
        end_of_test();
    end
endmodule // test_pad_decode
